// ==== design/hblank_pkg.sv ====
// Constants, register map and carrier types for the horizontal clamp and blank generator
`default_nettype none
package hblank_pkg;
   // ==========================================================
   // Counters and serial word
   localparam int         POS_W          = 13;
   localparam int         SER_ADDR_W     = 8;
   localparam int         SER_DATA_W     = 16;
   localparam int         SER_WORD_BITS  = SER_ADDR_W + SER_DATA_W;
   localparam int         MASK_AREAS     = 3;
   localparam int         BLANK_TOGGLES  = 6;
   localparam int         MAX_SEQ        = 4;
   localparam logic [12:0] POS_MAX       = 13'h1fff;
   localparam logic [12:0] POS_ZERO      = 13'h0000;

   // ==========================================================
   // Register map: per-sequence block at seq * stride, globals above
   localparam logic [7:0] GLOBAL_BIT_MASK = 8'h80;
   localparam logic [4:0] OFS_POLARITY    = 5'h00;
   localparam logic [4:0] OFS_CLAMP_TOG1  = 5'h01;
   localparam logic [4:0] OFS_CLAMP_TOG2  = 5'h02;
   localparam logic [4:0] OFS_PIX_TOG1    = 5'h03;
   localparam logic [4:0] OFS_PIX_TOG2    = 5'h04;
   localparam logic [4:0] OFS_BLANK_CTL   = 5'h05;
   localparam logic [4:0] OFS_ODD_TOG     = 5'h08;
   localparam logic [4:0] OFS_EVEN_TOG    = 5'h10;
   localparam logic [7:0] GLB_CLAMP_START = 8'h80;
   localparam logic [7:0] GLB_CLAMP_END   = 8'h84;
   localparam logic [7:0] GLB_PIX_START   = 8'h88;
   localparam logic [7:0] GLB_PIX_END     = 8'h8c;

   // ==========================================================
   // Field positions
   localparam int BIT_CLAMP_POL = 0;
   localparam int BIT_PIX_POL   = 1;
   localparam int BIT_MODE_LO   = 0;
   localparam int BIT_ODD_LVL   = 2;
   localparam int BIT_EVEN_LVL  = 3;
   localparam int BIT_LAST_LVL  = 4;

   typedef enum logic [1:0] {
      BLANK_MODE_NORMAL,
      BLANK_MODE_MIXING,
      BLANK_MODE_ADVANCED,
      BLANK_MODE_TEST
   } blank_mode_e;

   typedef struct packed {
      logic                               clamp_pol;
      logic                               pix_pol;
      logic [POS_W-1:0]                   clamp_tog1;
      logic [POS_W-1:0]                   clamp_tog2;
      logic [POS_W-1:0]                   pix_tog1;
      logic [POS_W-1:0]                   pix_tog2;
      blank_mode_e                        mode;
      logic                               odd_lvl;
      logic                               even_lvl;
      logic                               last_lvl;
      logic [BLANK_TOGGLES-1:0][POS_W-1:0] odd_tog;
      logic [BLANK_TOGGLES-1:0][POS_W-1:0] even_tog;
   } seq_cfg_s;

   typedef struct packed {
      logic [SER_ADDR_W-1:0] addr;
      logic [SER_DATA_W-1:0] data;
   } ser_word_s;

   // ==========================================================
   // Reset values: clamp and pixel blank start inactive high, masks start disabled
   localparam seq_cfg_s SEQ_CFG_RESET = '{
      clamp_pol:  1'b1,
      pix_pol:    1'b1,
      clamp_tog1: POS_MAX,
      clamp_tog2: POS_MAX,
      pix_tog1:   POS_MAX,
      pix_tog2:   POS_MAX,
      mode:       BLANK_MODE_NORMAL,
      odd_lvl:    1'b0,
      even_lvl:   1'b0,
      last_lvl:   1'b0,
      odd_tog:    {BLANK_TOGGLES{POS_MAX}},
      even_tog:   {BLANK_TOGGLES{POS_MAX}}
   };
   localparam logic [12:0] MASK_START_RESET = POS_MAX;
   localparam logic [12:0] MASK_END_RESET   = POS_ZERO;
endpackage : hblank_pkg
`default_nettype wire

// ==== design/horiz_clamp_blank_gen.sv ====
// Horizontal clamp, pixel blank and horizontal blank pulse generator with serial register port
`default_nettype none
module horiz_clamp_blank_gen #(
   parameter int NUM_SEQ = 4
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ser_load_n,
   input  wire logic        i_ser_clk,
   input  wire logic        i_ser_data,
   input  wire logic        i_line_sync,
   input  wire logic        i_field_sync,
   input  wire logic [1:0]  i_seq_sel,
   input  wire logic        i_hclk_a,
   input  wire logic        i_hclk_b,
   input  wire logic        i_last_stage,
   output logic             o_black_clamp_pulse,
   output logic             o_pixel_blank_pulse,
   output logic             o_horiz_blank_pulse,
   output logic             o_hclk_phase_a,
   output logic             o_hclk_phase_b,
   output logic             o_last_stage_clock,
   output logic [12:0]      o_pixel_count,
   output logic [12:0]      o_line_count
);
   localparam int PW = hblank_pkg::POS_W;

   if (NUM_SEQ < 1 || NUM_SEQ > hblank_pkg::MAX_SEQ) begin : g_bad_num_seq
      $error("NUM_SEQ must lie between 1 and 4");
   end

   // ==========================================================
   // Pin synchronisers
   logic [1:0] sync_load;
   logic [1:0] sync_sclk;
   logic [1:0] sync_sdat;
   logic [1:0] sync_line;
   logic [1:0] sync_field;
   logic       sclk_prev;
   logic       line_prev;
   logic       field_prev;
   logic       load_prev;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         sync_load  <= 2'h3;
         sync_sclk  <= 2'h0;
         sync_sdat  <= 2'h0;
         sync_line  <= 2'h0;
         sync_field <= 2'h0;
         sclk_prev  <= 1'b0;
         line_prev  <= 1'b0;
         field_prev <= 1'b0;
         load_prev  <= 1'b1;
      end else begin
         sync_load  <= {sync_load[0], i_ser_load_n};
         sync_sclk  <= {sync_sclk[0], i_ser_clk};
         sync_sdat  <= {sync_sdat[0], i_ser_data};
         sync_line  <= {sync_line[0], i_line_sync};
         sync_field <= {sync_field[0], i_field_sync};
         sclk_prev  <= sync_sclk[1];
         line_prev  <= sync_line[1];
         field_prev <= sync_field[1];
         load_prev  <= sync_load[1];
      end
   end

   logic line_start;
   logic field_start;
   logic sclk_rise;
   logic load_end;
   assign line_start  = sync_line[1] & ~line_prev;
   assign field_start = sync_field[1] & ~field_prev;
   assign sclk_rise   = sync_sclk[1] & ~sclk_prev;
   assign load_end    = sync_load[1] & ~load_prev;

   // ==========================================================
   // Serial write port: MSB first, address then data, taken at load release
   logic [hblank_pkg::SER_WORD_BITS-1:0] ser_shift;
   logic [4:0]                           ser_count;
   logic                                 wr_valid;
   hblank_pkg::ser_word_s                wr_word;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ser_shift <= '0;
         ser_count <= 5'h00;
         wr_valid  <= 1'b0;
         wr_word   <= '0;
      end else begin
         wr_valid <= 1'b0;
         if (!sync_load[1] && sclk_rise) begin
            ser_shift <= {ser_shift[hblank_pkg::SER_WORD_BITS-2:0], sync_sdat[1]};
            if (ser_count != 5'h1f) begin
               ser_count <= ser_count + 5'h01;
            end
         end
         if (load_end) begin
            // A frame of the wrong length is dropped rather than half-applied
            wr_valid  <= (ser_count == 5'(hblank_pkg::SER_WORD_BITS));
            wr_word   <= ser_shift;
            ser_count <= 5'h00;
         end
      end
   end

   // ==========================================================
   // Register file
   hblank_pkg::seq_cfg_s seq_cfg [NUM_SEQ];
   logic [2:0][PW-1:0]   clamp_mask_start;
   logic [2:0][PW-1:0]   clamp_mask_end;
   logic [2:0][PW-1:0]   pix_mask_start;
   logic [2:0][PW-1:0]   pix_mask_end;

   logic [1:0]    wr_seq;
   logic [4:0]    wr_ofs;
   logic [1:0]    wr_area;
   logic [12:0]   wr_pos;
   assign wr_seq  = wr_word.addr[6:5];
   assign wr_ofs  = wr_word.addr[4:0];
   assign wr_area = wr_word.addr[1:0];
   assign wr_pos  = wr_word.data[PW-1:0];

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         for (int s = 0; s < NUM_SEQ; s++) begin
            seq_cfg[s] <= hblank_pkg::SEQ_CFG_RESET;
         end
      end else if (wr_valid && !wr_word.addr[7] && 32'(wr_seq) < NUM_SEQ) begin
         case (wr_ofs)
            hblank_pkg::OFS_POLARITY: begin
               seq_cfg[wr_seq].clamp_pol <= wr_word.data[hblank_pkg::BIT_CLAMP_POL];
               seq_cfg[wr_seq].pix_pol   <= wr_word.data[hblank_pkg::BIT_PIX_POL];
            end
            hblank_pkg::OFS_CLAMP_TOG1: seq_cfg[wr_seq].clamp_tog1 <= wr_pos;
            hblank_pkg::OFS_CLAMP_TOG2: seq_cfg[wr_seq].clamp_tog2 <= wr_pos;
            hblank_pkg::OFS_PIX_TOG1:   seq_cfg[wr_seq].pix_tog1   <= wr_pos;
            hblank_pkg::OFS_PIX_TOG2:   seq_cfg[wr_seq].pix_tog2   <= wr_pos;
            hblank_pkg::OFS_BLANK_CTL: begin
               seq_cfg[wr_seq].mode <= hblank_pkg::blank_mode_e'(
                  wr_word.data[hblank_pkg::BIT_MODE_LO +: 2]);
               seq_cfg[wr_seq].odd_lvl  <= wr_word.data[hblank_pkg::BIT_ODD_LVL];
               seq_cfg[wr_seq].even_lvl <= wr_word.data[hblank_pkg::BIT_EVEN_LVL];
               seq_cfg[wr_seq].last_lvl <= wr_word.data[hblank_pkg::BIT_LAST_LVL];
            end
            default: begin
               for (int k = 0; k < hblank_pkg::BLANK_TOGGLES; k++) begin
                  if (wr_ofs == hblank_pkg::OFS_ODD_TOG + 5'(k)) begin
                     seq_cfg[wr_seq].odd_tog[k] <= wr_pos;
                  end
                  if (wr_ofs == hblank_pkg::OFS_EVEN_TOG + 5'(k)) begin
                     seq_cfg[wr_seq].even_tog[k] <= wr_pos;
                  end
               end
            end
         endcase
      end
   end

   // Mask areas are shared by all sequences
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         clamp_mask_start <= {3{hblank_pkg::MASK_START_RESET}};
         clamp_mask_end   <= {3{hblank_pkg::MASK_END_RESET}};
         pix_mask_start   <= {3{hblank_pkg::MASK_START_RESET}};
         pix_mask_end     <= {3{hblank_pkg::MASK_END_RESET}};
      end else if (wr_valid && wr_word.addr[7] && wr_area != 2'h3) begin
         case (wr_word.addr & ~8'h03)
            hblank_pkg::GLB_CLAMP_START: clamp_mask_start[wr_area] <= wr_pos;
            hblank_pkg::GLB_CLAMP_END:   clamp_mask_end[wr_area]   <= wr_pos;
            hblank_pkg::GLB_PIX_START:   pix_mask_start[wr_area]   <= wr_pos;
            hblank_pkg::GLB_PIX_END:     pix_mask_end[wr_area]     <= wr_pos;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Counters
   logic [PW-1:0] pix_count;
   logic [PW-1:0] line_count;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pix_count  <= '0;
         line_count <= hblank_pkg::POS_MAX;
      end else begin
         pix_count <= line_start ? '0 : pix_count + 13'h0001;
         if (field_start && line_start) begin
            line_count <= '0;
         end else if (field_start) begin
            // Wraps to line 0 on the first line start of the field
            line_count <= hblank_pkg::POS_MAX;
         end else if (line_start) begin
            line_count <= line_count + 13'h0001;
         end
      end
   end
   assign o_pixel_count = pix_count;
   assign o_line_count  = line_count;

   // ==========================================================
   // Pattern generation
   hblank_pkg::seq_cfg_s cur;
   logic [1:0]           act_seq;
   assign act_seq = (32'(i_seq_sel) < NUM_SEQ) ? i_seq_sel : 2'h0;
   assign cur     = seq_cfg[act_seq];

   function automatic logic in_mask(input logic [12:0] line,
                                    input logic [2:0][12:0] st,
                                    input logic [2:0][12:0] en);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < hblank_pkg::MASK_AREAS; k++) begin
         if (st[k] <= en[k] && line >= st[k] && line <= en[k]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : in_mask

   logic clamp_state;
   logic pix_state;
   logic blank_state;
   logic clamp_hit;
   logic pix_hit;
   logic blank_hit;
   logic clamp_masked;
   logic pix_masked;
   logic [hblank_pkg::BLANK_TOGGLES-1:0][PW-1:0] blank_tog;

   assign clamp_hit = (pix_count == cur.clamp_tog1) || (pix_count == cur.clamp_tog2);
   assign pix_hit   = (pix_count == cur.pix_tog1) || (pix_count == cur.pix_tog2);
   assign blank_tog = line_count[0] ? cur.odd_tog : cur.even_tog;

   always_comb begin
      blank_hit = 1'b0;
      for (int k = 0; k < hblank_pkg::BLANK_TOGGLES; k++) begin
         if (pix_count == blank_tog[k]) begin
            blank_hit = 1'b1;
         end
      end
   end

   assign clamp_masked = in_mask(line_count, clamp_mask_start, clamp_mask_end);
   assign pix_masked   = in_mask(line_count, pix_mask_start, pix_mask_end);

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         clamp_state <= 1'b1;
         pix_state   <= 1'b1;
      end else if (line_start) begin
         clamp_state <= cur.clamp_pol;
         pix_state   <= cur.pix_pol;
      end else begin
         clamp_state <= clamp_state ^ clamp_hit;
         pix_state   <= pix_state ^ pix_hit;
      end
   end

   // Only mode 0 toggling is built; modes 1 and 2 fall back to it, test mode keeps blank off
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         blank_state <= 1'b0;
      end else if (line_start || cur.mode == hblank_pkg::BLANK_MODE_TEST) begin
         blank_state <= 1'b0;
      end else begin
         blank_state <= blank_state ^ blank_hit;
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_black_clamp_pulse <= 1'b1;
         o_pixel_blank_pulse <= 1'b1;
         o_horiz_blank_pulse <= 1'b0;
         o_hclk_phase_a      <= 1'b0;
         o_hclk_phase_b      <= 1'b0;
         o_last_stage_clock  <= 1'b0;
      end else begin
         o_black_clamp_pulse <= clamp_state | clamp_masked;
         o_pixel_blank_pulse <= pix_state | pix_masked;
         o_horiz_blank_pulse <= blank_state;
         o_hclk_phase_a      <= blank_state ? ~cur.odd_lvl : i_hclk_a;
         o_hclk_phase_b      <= blank_state ? ~cur.even_lvl : i_hclk_b;
         o_last_stage_clock  <= blank_state ? ~cur.last_lvl : i_last_stage;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   a_clamp_start_pol: assert property (
      line_start |=> clamp_state == $past(cur.clamp_pol))
      else $error("clamp did not take start polarity");
   a_pix_start_pol: assert property (line_start |=> pix_state == $past(cur.pix_pol))
      else $error("pixel blank did not take start polarity");
   a_clamp_toggle: assert property (
      !line_start && clamp_hit |=> clamp_state != $past(clamp_state))
      else $error("clamp missed a toggle");
   a_clamp_hold: assert property (!line_start && !clamp_hit |=> $stable(clamp_state))
      else $error("clamp changed without a toggle");
   a_clamp_masked_high: assert property (clamp_masked |=> o_black_clamp_pulse)
      else $error("masked clamp not high");
   a_pix_masked_high: assert property (pix_masked |=> o_pixel_blank_pulse)
      else $error("masked pixel blank not high");
   a_blank_line_start: assert property (
      line_start |=> !blank_state ##1 !o_horiz_blank_pulse)
      else $error("blank not cleared at line start");
   a_blank_toggle: assert property (
      !line_start && blank_hit && cur.mode != hblank_pkg::BLANK_MODE_TEST
      |=> blank_state != $past(blank_state))
      else $error("blank missed a toggle");
   a_odd_group_level: assert property (
      blank_state |=> o_hclk_phase_a == ~$past(cur.odd_lvl))
      else $error("odd clocks not at mask level");
   a_hclk_pass: assert property (!blank_state |=> o_hclk_phase_b == $past(i_hclk_b))
      else $error("even clocks not passed outside blank");
   a_pixel_advance: assert property (
      !line_start |=> pix_count == 13'($past(pix_count) + 13'h0001))
      else $error("pixel counter did not advance");

   c_clamp_toggle: cover property (clamp_hit && !line_start);
   c_clamp_masked: cover property (clamp_masked && line_start);
   c_blank_odd_low: cover property (blank_state && cur.odd_lvl ##1 !o_hclk_phase_a);
   c_reg_write: cover property (wr_valid && !wr_word.addr[7]);
endmodule : horiz_clamp_blank_gen
`default_nettype wire

// ==== dv/ccd_front_model.sv ====
// Model of the timing core horizontal clocks and of the front end that watches the clamp
`default_nettype none
module ccd_front_model (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_black_clamp_pulse,
   output logic      o_hclk_a,
   output logic      o_hclk_b,
   output logic      o_last_stage,
   output int        o_clamp_cycles
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] phase;

   // ============================================================
   // Clocks: the phases stay complementary, the last stage runs slower so it decorrelates
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         phase        <= 2'h0;
         o_hclk_a     <= 1'b0;
         o_hclk_b     <= 1'b1;
         o_last_stage <= 1'b0;
      end else begin
         phase        <= phase + 2'h1;
         o_hclk_a     <= ~o_hclk_a;
         o_hclk_b     <= o_hclk_a;
         o_last_stage <= phase[1];
      end
   end

   // ============================================================
   // Front end clamps only while the pulse is low
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_clamp_cycles <= 0;
      end else if (!i_black_clamp_pulse) begin
         o_clamp_cycles <= o_clamp_cycles + 1;
      end
   end
endmodule : ccd_front_model
`default_nettype wire

// ==== dv/tb_horiz_clamp_blank_gen.sv ====
// Self-checking bench for the horizontal clamp and blank generator
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %0t ns got %b expected %b", $time, got, exp); end end
module tb_horiz_clamp_blank_gen;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LINE_LEN = 300;
   localparam int LIMIT    = 60000;
   logic i_core_clk, i_rst, i_ser_load_n, i_ser_clk, i_ser_data, i_line_sync, i_field_sync;
   logic i_hclk_a, i_hclk_b, i_last_stage, last_a, last_b, last_l;
   logic [1:0]  i_seq_sel;
   logic o_black_clamp_pulse, o_pixel_blank_pulse, o_horiz_blank_pulse;
   logic o_hclk_phase_a, o_hclk_phase_b, o_last_stage_clock;
   logic [12:0] o_pixel_count, o_line_count;
   int failures, samples_checked, cycles, clamp_cycles;
   logic            pol_c [4], pol_p [4];
   logic [1:0]      mode [4];
   logic [2:0]      lvl [4];
   logic [1:0][12:0] ct [4], pt [4];
   logic [5:0][12:0] ot [4], et [4];
   logic [2:0][12:0] cs, ce, ps, pe;

   horiz_clamp_blank_gen #(.NUM_SEQ(4)) horiz_clamp_blank_gen_i (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ser_load_n(i_ser_load_n),
      .i_ser_clk(i_ser_clk), .i_ser_data(i_ser_data), .i_line_sync(i_line_sync),
      .i_field_sync(i_field_sync), .i_seq_sel(i_seq_sel), .i_hclk_a(i_hclk_a),
      .i_hclk_b(i_hclk_b), .i_last_stage(i_last_stage),
      .o_black_clamp_pulse(o_black_clamp_pulse), .o_pixel_blank_pulse(o_pixel_blank_pulse),
      .o_horiz_blank_pulse(o_horiz_blank_pulse), .o_hclk_phase_a(o_hclk_phase_a),
      .o_hclk_phase_b(o_hclk_phase_b), .o_last_stage_clock(o_last_stage_clock),
      .o_pixel_count(o_pixel_count), .o_line_count(o_line_count));

   ccd_front_model ccd_front_model_i (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_black_clamp_pulse(o_black_clamp_pulse),
      .o_hclk_a(i_hclk_a), .o_hclk_b(i_hclk_b), .o_last_stage(i_last_stage),
      .o_clamp_cycles(clamp_cycles));

   initial begin
      i_core_clk = 1'b0;
      forever #25 i_core_clk = ~i_core_clk;
   end

   // Outputs outside blank are the incoming clocks one edge late
   always @(posedge i_core_clk) begin
      last_a <= i_hclk_a;
      last_b <= i_hclk_b;
      last_l <= i_last_stage;
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         failures++;
         tally_and_finish();
      end
   end

   // ============================================================
   // Expectation helpers
   function automatic logic flips(input logic init, input logic [5:0][12:0] t, input int p);
      logic s;
      logic dup;
      s = init;
      for (int i = 0; i < 6; i++) begin
         dup = 1'b0;
         for (int j = 0; j < i; j++) dup |= (t[j] == t[i]);
         if (int'(t[i]) <= p && !dup) s = ~s;
      end
      return s;
   endfunction : flips

   function automatic logic masked(input logic [2:0][12:0] s, input logic [2:0][12:0] e,
                                   input int ln);
      for (int i = 0; i < 3; i++) if (s[i] <= e[i] && ln >= int'(s[i]) && ln <= int'(e[i]))
         return 1'b1;
      return 1'b0;
   endfunction : masked

   function automatic logic [7:0] adr(input int s, input logic [4:0] ofs);
      return {1'b0, 2'(s), ofs};
   endfunction : adr

   // ============================================================
   // Serial port and line drivers
   task automatic ser_write(input logic [7:0] a, input logic [15:0] d);
      hblank_pkg::ser_word_s w;
      w.addr = a;
      w.data = d;
      @(posedge i_core_clk);
      i_ser_load_n <= 1'b0;
      for (int i = hblank_pkg::SER_WORD_BITS - 1; i >= 0; i--) begin
         @(posedge i_core_clk);
         i_ser_data <= w[i];
         repeat (4) @(posedge i_core_clk);
         i_ser_clk <= 1'b1;
         repeat (4) @(posedge i_core_clk);
         i_ser_clk <= 1'b0;
      end
      repeat (4) @(posedge i_core_clk);
      i_ser_load_n <= 1'b1;
      i_ser_data <= ~i_ser_data;
      repeat (8) @(posedge i_core_clk);
   endtask : ser_write

   task automatic write_masks();
      for (int a = 0; a < 3; a++) begin
         ser_write(hblank_pkg::GLB_CLAMP_START + 8'(a), {3'h0, cs[a]});
         ser_write(hblank_pkg::GLB_CLAMP_END + 8'(a), {3'h0, ce[a]});
         ser_write(hblank_pkg::GLB_PIX_START + 8'(a), {3'h0, ps[a]});
         ser_write(hblank_pkg::GLB_PIX_END + 8'(a), {3'h0, pe[a]});
      end
   endtask : write_masks

   task automatic run_line(input logic fld, input int ln, input int sq);
      logic [5:0][12:0] bt, c6, p6;
      logic c, pb, hb;
      int p;
      bt = ln[0] ? ot[sq] : et[sq];
      c6 = {{4{hblank_pkg::POS_MAX}}, ct[sq]};
      p6 = {{4{hblank_pkg::POS_MAX}}, pt[sq]};
      i_seq_sel <= 2'(sq);
      repeat (3) @(posedge i_core_clk);
      i_line_sync <= 1'b1;
      i_field_sync <= fld;
      for (int k = 1; k <= LINE_LEN; k++) begin
         @(posedge i_core_clk);
         if (k == 4) begin
            i_line_sync <= 1'b0;
            i_field_sync <= 1'b0;
         end
         #1;
         // Line start lands three edges after the pin, a toggle reaches the pin two later
         p = k - 5;
         if (p > 3) begin
            `CHECK(o_pixel_count, 13'(k - 3))
            c = masked(cs, ce, ln) ? 1'b1 : flips(pol_c[sq], c6, p);
            pb = masked(ps, pe, ln) ? 1'b1 : flips(pol_p[sq], p6, p);
            hb = (mode[sq] == 2'h3) ? 1'b0 : flips(1'b0, bt, p);
            `CHECK(o_black_clamp_pulse, c)
            `CHECK(o_pixel_blank_pulse, pb)
            `CHECK(o_horiz_blank_pulse, hb)
            `CHECK(o_hclk_phase_a, hb ? ~lvl[sq][0] : last_a)
            `CHECK(o_hclk_phase_b, hb ? ~lvl[sq][1] : last_b)
            `CHECK(o_last_stage_clock, hb ? ~lvl[sq][2] : last_l)
            `CHECK(o_line_count, 13'(ln))
         end
      end
   endtask : run_line

   task automatic tally_and_finish();
      $display("mismatches %0d, comparisons %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   // ============================================================
   // Main sequence
   initial begin
      void'($urandom(9450));
      {failures, samples_checked, cycles} = '0;
      {i_rst, i_ser_load_n, i_ser_clk, i_ser_data} = 4'b1100;
      {i_line_sync, i_field_sync, i_seq_sel} = '0;
      for (int s = 0; s < 4; s++) begin
         {pol_c[s], pol_p[s], mode[s], lvl[s]} = 7'b1100000;
         ct[s] = {2{hblank_pkg::POS_MAX}};
         pt[s] = {2{hblank_pkg::POS_MAX}};
         ot[s] = {6{hblank_pkg::POS_MAX}};
         et[s] = {6{hblank_pkg::POS_MAX}};
      end
      cs = {3{hblank_pkg::MASK_START_RESET}};
      ps = {3{hblank_pkg::MASK_START_RESET}};
      ce = {3{hblank_pkg::MASK_END_RESET}};
      pe = {3{hblank_pkg::MASK_END_RESET}};
      repeat (4) @(posedge i_core_clk);
      i_rst <= 1'b0;
      run_line(1'b1, 0, 0);
      write_masks();
      for (int s = 0; s < 4; s++) begin
         {pol_c[s], pol_p[s], lvl[s]} = 5'($urandom);
         mode[s] = 2'(s % 3);
         ct[s][0] = 13'(20 + $urandom_range(59));
         ct[s][1] = ct[s][0] + 13'(15 + $urandom_range(59));
         pt[s][0] = 13'(20 + $urandom_range(59));
         pt[s][1] = pt[s][0] + 13'(15 + $urandom_range(59));
         for (int i = 0; i < 6; i++) begin
            ot[s][i] = 13'(10 + 36 * i + $urandom_range(24));
            et[s][i] = 13'(10 + 36 * i + $urandom_range(24));
         end
      end
      // Equal toggles flip once; an unreachable toggle leaves blank open to line end
      ct[0][1] = ct[0][0];
      et[2][5] = hblank_pkg::POS_MAX;
      for (int s = 0; s < 4; s++) begin
         ser_write(adr(s, hblank_pkg::OFS_POLARITY), {14'h0, pol_p[s], pol_c[s]});
         ser_write(adr(s, hblank_pkg::OFS_CLAMP_TOG1), {3'h0, ct[s][0]});
         ser_write(adr(s, hblank_pkg::OFS_CLAMP_TOG2), {3'h0, ct[s][1]});
         ser_write(adr(s, hblank_pkg::OFS_PIX_TOG1), {3'h0, pt[s][0]});
         ser_write(adr(s, hblank_pkg::OFS_PIX_TOG2), {3'h0, pt[s][1]});
         ser_write(adr(s, hblank_pkg::OFS_BLANK_CTL), {11'h0, lvl[s], mode[s]});
         for (int i = 0; i < 6; i++) begin
            ser_write(adr(s, hblank_pkg::OFS_ODD_TOG + 5'(i)), {3'h0, ot[s][i]});
            ser_write(adr(s, hblank_pkg::OFS_EVEN_TOG + 5'(i)), {3'h0, et[s][i]});
         end
      end
      // Writes that must be ignored: unmapped offset and a fourth mask area
      ser_write(adr(0, 5'h06), 16'h0000);
      ser_write(hblank_pkg::GLB_CLAMP_START + 8'h03, 16'h0000);
      {cs[0], ce[0], cs[2], ce[2], ps[1], pe[1]} = {13'h2, 13'h3, 13'h6, 13'h4, 13'h5, 13'h5};
      write_masks();
      for (int ln = 0; ln < 8; ln++) run_line(ln == 0, ln, ln >> 1);
      cs[0] = hblank_pkg::POS_MAX;
      ser_write(hblank_pkg::GLB_CLAMP_START, {3'h0, cs[0]});
      for (int ln = 0; ln < 8; ln++) run_line(ln == 0, ln, ((ln >> 1) + 1) % 4);
      `CHECK(clamp_cycles > 0, 1'b1)
      tally_and_finish();
   end
endmodule : tb_horiz_clamp_blank_gen
`default_nettype wire
